//--- rtl/peu_params.svh
// Offsets, field positions, reset values and timing constants of the event unit
`ifndef PEU_PARAMS_SVH
`define PEU_PARAMS_SVH

// Register offsets
`define PEU_ADDR_STAT0 8'h05
`define PEU_ADDR_MASK0 8'h06
`define PEU_ADDR_SENSE0 8'h07
`define PEU_ADDR_STAT1 8'h08
`define PEU_ADDR_MASK1 8'h09
`define PEU_ADDR_SENSE1 8'h0a
`define PEU_ADDR_STAT3 8'h0e
`define PEU_ADDR_MASK3 8'h0f
`define PEU_ADDR_SENSE3 8'h10
`define PEU_ADDR_STAT4 8'h11
`define PEU_ADDR_MASK4 8'h12
`define PEU_ADDR_SENSE4 8'h13

// Event index within the internal flag vector
`define PEU_EV_BUTTON 0
`define PEU_EV_UNDERVOLT 1
`define PEU_EV_TEMP_A 2
`define PEU_EV_BUCK 6
`define PEU_EV_BOOST 7
`define PEU_EV_FUSE 8
`define PEU_EV_LINREG 9
`define PEU_NUM_EV 10
`define PEU_NUM_PIN 11
`define PEU_PIN_FUSE_SUPPLY 10

// Bit positions inside the external bytes
`define PEU_FUSE_BYTE_BIT 7
`define PEU_SUPPLY_SENSE_BIT 7

// Reset values
`define PEU_FLAGS_RST 10'h000
`define PEU_MASK_RST 10'h3ff
`define PEU_RDATA_RST 8'h00

// Timing: clock, debounce timebase and printed debounce times
`define PEU_CLK_PERIOD_NS 4
`define PEU_TICK_NS 1000
`define PEU_TICK_CYCLES (`PEU_TICK_NS / `PEU_CLK_PERIOD_NS)
`define PEU_T_UNDERVOLT_MS 3.9
`define PEU_T_BUTTON_MS 31.25
`define PEU_T_TEMP_MS 3.9
`define PEU_T_OVERCUR_MS 8.0
`define PEU_NS_PER_MS 1.0e6

`endif

//--- rtl/peu_pkg.sv
// Types shared by the event interrupt unit
`include "peu_params.svh"
package peu_pkg;
   typedef logic [`PEU_NUM_EV-1:0] peu_flags_t;
   typedef logic [19:0] peu_count_t;
   typedef enum logic [2:0] {
      PEU_TRIG_RISE = 3'h1,
      PEU_TRIG_FALL = 3'h2,
      PEU_TRIG_BOTH = 3'h4
   } peu_trig_t;
   typedef enum logic [3:0] {
      PEU_K_NONE = 4'h1,
      PEU_K_STAT = 4'h2,
      PEU_K_MASK = 4'h4,
      PEU_K_SENSE = 4'h8
   } peu_kind_t;
endpackage : peu_pkg

//--- rtl/peu_dbnc_if.sv
// Link between the event unit and one debouncer
interface peu_dbnc_if;
   import peu_pkg::*;
   logic raw;
   logic tick;
   peu_count_t lim_rise;
   peu_count_t lim_fall;
   logic level;
   logic rise;
   logic fall;
   modport ctl (output raw, output tick, output lim_rise, output lim_fall,
                input level, input rise, input fall);
   modport dbn (input raw, input tick, input lim_rise, input lim_fall,
                output level, output rise, output fall);
endinterface : peu_dbnc_if

//--- rtl/peu_debouncer.sv
// Edge qualifier: a level change is accepted only after it holds for its limit
module peu_debouncer
   import peu_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   peu_dbnc_if.dbn bus
);
   peu_count_t cnt_q, cnt_d;
   logic lvl_q, lvl_d;
   logic rise_q, rise_d;
   logic fall_q, fall_d;
   peu_count_t lim;

   always_comb begin
      lim = bus.raw ? bus.lim_rise : bus.lim_fall;
      cnt_d = cnt_q;
      lvl_d = lvl_q;
      rise_d = 1'b0;
      fall_d = 1'b0;
      if (bus.raw == lvl_q) begin
         cnt_d = '0;
      end else if (bus.tick) begin
         if (cnt_q + 20'h0_0001 >= lim) begin
            lvl_d = bus.raw;
            cnt_d = '0;
            rise_d = bus.raw;
            fall_d = ~bus.raw;
         end else begin
            cnt_d = cnt_q + 20'h0_0001;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lvl_q <= lvl_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign bus.level = lvl_q;
   assign bus.rise = rise_q;
   assign bus.fall = fall_q;

   // Separate tally of ticks since the raw level last moved, so the hold check
   // does not lean on the qualifier's own counter
   logic raw_q;
   peu_count_t hold_q, hold_d;

   always_comb begin
      hold_d = hold_q;
      if (bus.raw != raw_q) begin
         hold_d = bus.tick ? 20'h0_0001 : 20'h0_0000;
      end else if (bus.tick && hold_q != '1) begin
         hold_d = hold_q + 20'h0_0001;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         raw_q <= 1'b0;
         hold_q <= '0;
      end else begin
         raw_q <= bus.raw;
         hold_q <= hold_d;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_bounce;
      (bus.raw != lvl_q) ##1 (bus.raw == lvl_q);
   endsequence

   chk_bounce_restart: assert property (s_bounce |=> cnt_q == '0)
      else $error("debounce count not restarted after a bounce");
   chk_edge_needs_hold: assert property ((rise_d || fall_d) |-> hold_d >= lim)
      else $error("edge accepted before the hold time");
endmodule : peu_debouncer

//--- rtl/peu_event_unit.sv
// Event flags, masks, sense bits and interrupt line of the power controller
`include "peu_params.svh"

module peu_event_unit
   import peu_pkg::*;
#(
   parameter int unsigned DB_UNDERVOLT_TICKS =
      int'(`PEU_T_UNDERVOLT_MS * `PEU_NS_PER_MS / `PEU_TICK_NS),
   parameter int unsigned DB_BUTTON_TICKS =
      int'(`PEU_T_BUTTON_MS * `PEU_NS_PER_MS / `PEU_TICK_NS),
   parameter int unsigned DB_TEMP_TICKS =
      int'(`PEU_T_TEMP_MS * `PEU_NS_PER_MS / `PEU_TICK_NS),
   parameter int unsigned DB_OVERCUR_TICKS =
      int'(`PEU_T_OVERCUR_MS * `PEU_NS_PER_MS / `PEU_TICK_NS)
) (
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   // Event source pins
   input wire logic BUTTON_INPUT_IN,
   input wire logic SUPPLY_OK_IN,
   input wire logic [3:0] TEMP_ABOVE_IN,
   input wire logic BUCK_OC_IN,
   input wire logic BOOST_OC_IN,
   input wire logic LINREG_OC_IN,
   input wire logic FUSE_ERROR_IN,
   input wire logic FUSE_SUPPLY_PIN_IN,
   // Configuration from the control block
   input wire logic [1:0] BUTTON_DEBOUNCE_SEL_IN,
   // Register port from the serial engine
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_RD_IN,
   output logic [7:0] REG_RDATA_OUT,
   // Interrupt line to the host
   output logic IRQ_OUT_N
);
   localparam peu_trig_t TRIG [`PEU_NUM_EV] = '{PEU_TRIG_BOTH, PEU_TRIG_FALL,
      PEU_TRIG_BOTH, PEU_TRIG_BOTH, PEU_TRIG_BOTH, PEU_TRIG_BOTH,
      PEU_TRIG_RISE, PEU_TRIG_RISE, PEU_TRIG_RISE, PEU_TRIG_RISE};

   function automatic peu_kind_t reg_kind(input logic [7:0] a);
      unique case (a)
         `PEU_ADDR_STAT0, `PEU_ADDR_STAT1, `PEU_ADDR_STAT3, `PEU_ADDR_STAT4:
            reg_kind = PEU_K_STAT;
         `PEU_ADDR_MASK0, `PEU_ADDR_MASK1, `PEU_ADDR_MASK3, `PEU_ADDR_MASK4:
            reg_kind = PEU_K_MASK;
         `PEU_ADDR_SENSE0, `PEU_ADDR_SENSE1, `PEU_ADDR_SENSE3, `PEU_ADDR_SENSE4:
            reg_kind = PEU_K_SENSE;
         default: reg_kind = PEU_K_NONE;
      endcase
   endfunction : reg_kind

   // Group 0 = 0x05..0x07, 1 = 0x08.., 2 = 0x0e.., 3 = 0x11..
   function automatic logic [1:0] reg_group(input logic [7:0] a);
      if (a >= `PEU_ADDR_STAT4) begin
         reg_group = 2'h3;
      end else if (a >= `PEU_ADDR_STAT3) begin
         reg_group = 2'h2;
      end else if (a >= `PEU_ADDR_STAT1) begin
         reg_group = 2'h1;
      end else begin
         reg_group = 2'h0;
      end
   endfunction : reg_group

   function automatic peu_flags_t byte_to_flags(input logic [1:0] g, input logic [7:0] b);
      byte_to_flags = '0;
      unique case (g)
         2'h0: byte_to_flags[5:0] = b[5:0];
         2'h1: byte_to_flags[`PEU_EV_BUCK] = b[0];
         2'h2: begin
            byte_to_flags[`PEU_EV_BOOST] = b[0];
            byte_to_flags[`PEU_EV_FUSE] = b[`PEU_FUSE_BYTE_BIT];
         end
         2'h3: byte_to_flags[`PEU_EV_LINREG] = b[0];
      endcase
   endfunction : byte_to_flags

   function automatic logic [7:0] flags_to_byte(input logic [1:0] g, input peu_flags_t f);
      flags_to_byte = '0;
      unique case (g)
         2'h0: flags_to_byte[5:0] = f[5:0];
         2'h1: flags_to_byte[0] = f[`PEU_EV_BUCK];
         2'h2: begin
            flags_to_byte[0] = f[`PEU_EV_BOOST];
            flags_to_byte[`PEU_FUSE_BYTE_BIT] = f[`PEU_EV_FUSE];
         end
         2'h3: flags_to_byte[0] = f[`PEU_EV_LINREG];
      endcase
   endfunction : flags_to_byte

   function automatic logic pick_edge(input peu_trig_t t, input logic r, input logic f);
      unique case (t)
         PEU_TRIG_RISE: pick_edge = r;
         PEU_TRIG_FALL: pick_edge = f;
         PEU_TRIG_BOTH: pick_edge = r | f;
      endcase
   endfunction : pick_edge

   // Pin synchronisers: stage one feeds stage two only
   logic [`PEU_NUM_PIN-1:0] pins, sync1_q, sync2_q;
   assign pins = {FUSE_SUPPLY_PIN_IN, LINREG_OC_IN, FUSE_ERROR_IN, BOOST_OC_IN,
                  BUCK_OC_IN, TEMP_ABOVE_IN, SUPPLY_OK_IN, BUTTON_INPUT_IN};

   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end

   // Debounce timebase, one pulse per microsecond
   logic [7:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = (tick_cnt_q == 8'(`PEU_TICK_CYCLES - 1));
      tick_cnt_d = tick_d ? 8'h00 : tick_cnt_q + 8'h01;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         tick_cnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   // Limits; the select only stretches falling qualification
   peu_count_t lim_rise [`PEU_NUM_EV];
   peu_count_t lim_fall [`PEU_NUM_EV];

   always_comb begin
      for (int i = 0; i < `PEU_NUM_EV; i++) begin
         if (i >= `PEU_EV_BUCK) begin
            lim_rise[i] = 20'(DB_OVERCUR_TICKS);
         end else begin
            lim_rise[i] = 20'(DB_TEMP_TICKS);
         end
         lim_fall[i] = lim_rise[i];
      end
      lim_rise[`PEU_EV_BUTTON] = 20'(DB_BUTTON_TICKS);
      lim_fall[`PEU_EV_BUTTON] = 20'(DB_BUTTON_TICKS) << BUTTON_DEBOUNCE_SEL_IN;
      lim_rise[`PEU_EV_UNDERVOLT] = 20'(DB_UNDERVOLT_TICKS);
      lim_fall[`PEU_EV_UNDERVOLT] = 20'(DB_UNDERVOLT_TICKS) << BUTTON_DEBOUNCE_SEL_IN;
   end

   peu_dbnc_if dbi [`PEU_NUM_EV] ();
   peu_flags_t set_vec, lvl_vec;

   for (genvar i = 0; i < `PEU_NUM_EV; i++) begin : g_src
      assign dbi[i].raw = sync2_q[i];
      assign dbi[i].tick = tick_q;
      assign dbi[i].lim_rise = lim_rise[i];
      assign dbi[i].lim_fall = lim_fall[i];
      assign lvl_vec[i] = dbi[i].level;
      assign set_vec[i] = pick_edge(TRIG[i], dbi[i].rise, dbi[i].fall);
      peu_debouncer u_dbnc (
         .clock_in(CLOCK_IN),
         .reset_n_in(RESET_N_IN),
         .bus(dbi[i].ctl)
      );
   end

   // Live sense: undervoltage is the inverse of supply-ok
   peu_flags_t sense_vec;
   assign sense_vec = sync2_q[`PEU_NUM_EV-1:0] ^ peu_flags_t'(1 << `PEU_EV_UNDERVOLT);

   // Flags, masks, read data and interrupt line
   peu_flags_t flags_q, flags_d, mask_q, mask_d, clr_vec, grp_bits;
   logic [7:0] rdata_q, rdata_d;
   logic irq_n_q, irq_n_d;
   peu_kind_t kind;
   logic [1:0] grp;

   always_comb begin
      kind = reg_kind(REG_ADDR_IN);
      grp = reg_group(REG_ADDR_IN);
      clr_vec = '0;
      mask_d = mask_q;
      // A mask write may only touch its own group, or it unmasks the others
      grp_bits = byte_to_flags(grp, 8'hff);
      if (REG_WR_IN && kind == PEU_K_STAT) begin
         clr_vec = byte_to_flags(grp, REG_WDATA_IN);
      end
      if (REG_WR_IN && kind == PEU_K_MASK) begin
         mask_d = (mask_q & ~grp_bits) | (byte_to_flags(grp, REG_WDATA_IN) & grp_bits);
      end
      flags_d = (flags_q & ~clr_vec) | set_vec;
      rdata_d = rdata_q;
      if (REG_RD_IN) begin
         unique case (kind)
            PEU_K_STAT: rdata_d = flags_to_byte(grp, flags_q);
            PEU_K_MASK: rdata_d = flags_to_byte(grp, mask_q);
            PEU_K_SENSE: begin
               rdata_d = flags_to_byte(grp, sense_vec);
               if (grp == 2'h0) begin
                  rdata_d[`PEU_SUPPLY_SENSE_BIT] = sync2_q[`PEU_PIN_FUSE_SUPPLY];
               end
            end
            PEU_K_NONE: rdata_d = 8'h00;
         endcase
      end
      irq_n_d = ~|(flags_q & ~mask_q);
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RESET_N_IN) begin
         flags_q <= `PEU_FLAGS_RST;
         mask_q <= `PEU_MASK_RST;
         rdata_q <= `PEU_RDATA_RST;
         irq_n_q <= 1'b1;
      end else begin
         flags_q <= flags_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
         irq_n_q <= irq_n_d;
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign IRQ_OUT_N = irq_n_q;

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);

   sequence s_unmask_pending;
      |($past(mask_q) & ~mask_q & flags_q);
   endsequence

   chk_irq_asserted: assert property (|(flags_q & ~mask_q) |=> !IRQ_OUT_N)
      else $error("pending unmasked flag but line high");
   chk_irq_released: assert property (!(|(flags_q & ~mask_q)) |=> IRQ_OUT_N)
      else $error("line low with nothing pending");
   chk_unmask_fires: assert property (s_unmask_pending |=> !IRQ_OUT_N)
      else $error("unmasking a set flag did not raise the line");
   chk_set_beats_clear: assert property (
      |set_vec |=> (flags_q & $past(set_vec)) == $past(set_vec))
      else $error("qualified event lost");
   chk_flag_sticky: assert property (
      ##1 ($past(flags_q) & ~$past(clr_vec) & ~flags_q) == '0)
      else $error("flag dropped without a clear");
   chk_mask_reset: assert property (@(posedge CLOCK_IN)
      $rose(RESET_N_IN) |-> mask_q == `PEU_MASK_RST && flags_q == `PEU_FLAGS_RST)
      else $error("mask or flags wrong after reset");
   chk_uv_on_fall: assert property (
      set_vec[`PEU_EV_UNDERVOLT] |-> !lvl_vec[`PEU_EV_UNDERVOLT])
      else $error("undervoltage event on supply rise");
   chk_oc_on_rise: assert property (
      |set_vec[9:6] |-> (set_vec[9:6] & ~lvl_vec[9:6]) == '0)
      else $error("overcurrent or fuse event on falling edge");
   chk_stat_unused: assert property (
      $past(REG_RD_IN && REG_ADDR_IN == `PEU_ADDR_STAT0)
      |-> REG_RDATA_OUT[7:6] == 2'h0 && REG_RDATA_OUT[5:0] == $past(flags_q[5:0]))
      else $error("status byte read wrong");
   chk_sense_supply: assert property (
      $past(REG_RD_IN && REG_ADDR_IN == `PEU_ADDR_SENSE0)
      |-> REG_RDATA_OUT[7] == $past(sync2_q[`PEU_PIN_FUSE_SUPPLY]) && !REG_RDATA_OUT[6])
      else $error("sense byte bits 7:6 wrong");
endmodule : peu_event_unit

//--- bench/peu_host_model.sv
// Host side of the register port: single-byte strobed reads and writes
module peu_host_model (
   // Clock
   input wire logic clock_in,
   // Read data from the unit
   input wire logic [7:0] rdata_in,
   // Register request
   output logic [7:0] addr_out,
   output logic wr_out,
   output logic [7:0] wdata_out,
   output logic rd_out
);
   timeunit 1ns;
   timeprecision 100ps;
   int idle_cycles = 0;

   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   // Released lines show the inverse, so a stale value is never mistaken for a live one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      repeat (idle_cycles + 1) @(posedge clock_in);
      #1;
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(posedge clock_in);
      #1;
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      repeat (idle_cycles + 1) @(posedge clock_in);
      #1;
      addr_out = a;
      rd_out = 1'b1;
      @(posedge clock_in);
      #1;
      rd_out = 1'b0;
      addr_out = ~a;
      @(posedge clock_in);
      #1;
      d = rdata_in;
   endtask : rd
endmodule : peu_host_model

//--- bench/tb_top.sv
// Self-checking bench for the event interrupt unit
`include "peu_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // Short debounce so a qualified event lands well inside WAIT_EV
   localparam int TK = 3;
   localparam int WAIT_EV = 1600;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic button = 1'b0;
   logic supply_ok = 1'b1;
   logic [3:0] temp = 4'h0;
   logic [3:0] flt = 4'h0;
   logic fuse_sup = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, irq_n;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [7:0] f_stat [4] = '{`PEU_ADDR_STAT1, `PEU_ADDR_STAT3, `PEU_ADDR_STAT4,
                              `PEU_ADDR_STAT3};
   logic [7:0] f_bit [4] = '{8'h01, 8'h01, 8'h01, 8'h80};

   always #2 clk = ~clk;

   peu_event_unit #(.DB_UNDERVOLT_TICKS(TK), .DB_BUTTON_TICKS(TK), .DB_TEMP_TICKS(TK),
      .DB_OVERCUR_TICKS(TK)) uut (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .BUTTON_INPUT_IN(button),
      .SUPPLY_OK_IN(supply_ok), .TEMP_ABOVE_IN(temp), .BUCK_OC_IN(flt[0]),
      .BOOST_OC_IN(flt[1]), .LINREG_OC_IN(flt[2]), .FUSE_ERROR_IN(flt[3]),
      .FUSE_SUPPLY_PIN_IN(fuse_sup), .BUTTON_DEBOUNCE_SEL_IN(sel),
      .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata), .IRQ_OUT_N(irq_n));

   peu_host_model host (.clock_in(clk), .rdata_in(rdata), .addr_out(addr),
      .wr_out(wr), .wdata_out(wdata), .rd_out(rd));

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk_byte(d, exp);
   endtask : expect_reg

   task automatic t_reset();
      expect_reg(`PEU_ADDR_STAT0, 8'h00);
      expect_reg(`PEU_ADDR_MASK0, 8'h3f);
      expect_reg(`PEU_ADDR_SENSE0, 8'h00);
      expect_reg(8'h20, 8'h00);
      chk_bit(irq_n, 1'b1);
   endtask : t_reset

   // Short glitch on button, supply, thermal and fuse-supply pins: sense follows, no event qualifies
   task automatic t_sense();
      {button, supply_ok, temp, fuse_sup} = {1'b1, 1'b0, 4'ha, 1'b1};
      wait_cyc(4);
      expect_reg(`PEU_ADDR_SENSE0, 8'hab);
      host.wr(`PEU_ADDR_SENSE0, 8'h00);
      expect_reg(`PEU_ADDR_SENSE0, 8'hab);
      {button, supply_ok, temp, fuse_sup} = {1'b0, 1'b1, 4'h0, 1'b0};
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h00);
      expect_reg(`PEU_ADDR_SENSE0, 8'h00);
   endtask : t_sense

   task automatic t_thermal();
      host.wr(`PEU_ADDR_MASK0, 8'h00);
      temp = 4'hf;
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h3c);
      chk_bit(irq_n, 1'b0);
      temp = 4'h0;
      host.wr(`PEU_ADDR_STAT0, 8'h3c);
      wait_cyc(2);
      chk_bit(irq_n, 1'b1);
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h3c);
      host.wr(`PEU_ADDR_STAT0, 8'h04);
      wait_cyc(2);
      chk_bit(irq_n, 1'b0);
      host.wr(`PEU_ADDR_MASK0, 8'h38);
      wait_cyc(2);
      chk_bit(irq_n, 1'b1);
      expect_reg(`PEU_ADDR_STAT0, 8'h38);
      host.wr(`PEU_ADDR_MASK0, 8'h00);
      wait_cyc(2);
      chk_bit(irq_n, 1'b0);
      host.wr(`PEU_ADDR_STAT0, 8'hff);
      wait_cyc(2);
      chk_bit(irq_n, 1'b1);
   endtask : t_thermal

   // Stretched falling debounce: x4 for undervoltage and button, rising unchanged
   task automatic t_stretch();
      sel = 2'h2;
      supply_ok = 1'b0;
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h00);
      wait_cyc(2000);
      expect_reg(`PEU_ADDR_STAT0, 8'h02);
      button = 1'b1;
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h03);
      host.wr(`PEU_ADDR_STAT0, 8'h03);
      button = 1'b0;
      supply_ok = 1'b1;
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h00);
      wait_cyc(2000);
      expect_reg(`PEU_ADDR_STAT0, 8'h01);
      host.wr(`PEU_ADDR_STAT0, 8'h01);
      sel = 2'h0;
      supply_ok = 1'b0;
      wait_cyc(WAIT_EV);
      expect_reg(`PEU_ADDR_STAT0, 8'h02);
      supply_ok = 1'b1;
      host.wr(`PEU_ADDR_STAT0, 8'h02);
   endtask : t_stretch

   // Overcurrent and fuse error: rising edge only, latched, masked at reset
   task automatic t_faults();
      host.idle_cycles = 3;
      for (int i = 0; i < 4; i++) begin
         flt = 4'h1 << i;
         wait_cyc(4);
         expect_reg(f_stat[i] + 8'h02, f_bit[i]);
         wait_cyc(WAIT_EV);
         expect_reg(f_stat[i], f_bit[i]);
         chk_bit(irq_n, 1'b1);
         host.wr(f_stat[i] + 8'h01, 8'h00);
         wait_cyc(2);
         chk_bit(irq_n, 1'b0);
         flt = 4'h0;
         wait_cyc(WAIT_EV);
         host.wr(f_stat[i], f_bit[i]);
         wait_cyc(2);
         chk_bit(irq_n, 1'b1);
         expect_reg(f_stat[i], 8'h00);
         host.wr(f_stat[i] + 8'h01, 8'hff);
      end
      host.idle_cycles = 0;
   endtask : t_faults

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_sense();
      t_thermal();
      t_stretch();
      t_faults();
      summarize();
   end

   // About 30k cycles expected; a hang counts as a mismatch
   initial begin
      #200us;
      n_mismatch++;
      summarize();
   end
endmodule : tb_top
